// File: design/fuse_code_map.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module fuse_code_map
    import fuse_map_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] field_duty,
    output logic [9:0] duty_select,
    output logic calibrating,
    output logic carrier_tick,
    output logic device_locked
);

    // -----------------------------------------------------------------
    // field saturation
    // -----------------------------------------------------------------
    function automatic logic [9:0] field_max(input logic [2:0] key);
        unique case (key)
            param_key_gain: field_max = gain_code_max;
            param_key_idle: field_max = idle_code_max;
            param_key_carrier: field_max = carrier_code_max;
            default: field_max = lock_code_max;
        endcase
    endfunction

    function automatic logic [9:0] clamp(input logic [2:0] key, input logic [9:0] code);
        clamp = (code > field_max(key)) ? field_max(key) : code;
    endfunction

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    field_set_type trial, next_trial;
    field_set_type blown, next_blown;
    logic [1:0] mode, next_mode;
    logic [2:0] key, next_key;
    logic cal_active, next_cal_active;
    logic [31:0] period_count, next_period_count;
    logic [15:0] periods_done, next_periods_done;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic [9:0] duty, next_duty;

    field_set_type effective;
    logic locked;
    logic [31:0] carrier_cycles;

    assign effective = trial | blown;
    assign locked = |(blown.lock & lock_code_fuse);
    assign carrier_cycles = 32'(carrier_base_cycles + 32'(effective.carrier) * carrier_step_cycles);

    // -----------------------------------------------------------------
    // bus handshake
    // -----------------------------------------------------------------
    logic do_write;
    logic do_read;
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign do_read = s_axi_arvalid && !rvalid;

    always_comb
    begin
        logic [31:0] cmd;
        logic [9:0] cur;
        logic [9:0] bit_sel;
        logic power_cycle;
        cmd = w_data;
        cur = 10'h000;
        bit_sel = 10'h000;
        power_cycle = 1'b0;
        next_trial = trial;
        next_blown = blown;
        next_mode = mode;
        next_key = key;
        next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
        next_w_held = w_held || (s_axi_wvalid && s_axi_wready);
        next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
        next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
        next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
        next_bvalid = bvalid && !s_axi_bready;
        next_bresp = bresp;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == addr_command) ? resp_okay : resp_slverr;
            if (aw_addr == addr_command && w_strb[1:0] == 2'h3)
            begin
                power_cycle = cmd[cmd_power_cycle_bit];
                if (power_cycle)
                begin
                    next_trial = '0;
                    next_mode = 2'h0;
                    next_key = 3'h0;
                end
                else if (!locked)
                begin
                    next_mode = cmd[cmd_mode_lsb +: 2];
                    next_key = cmd[cmd_key_lsb +: 3];
                    if (cmd[cmd_mode_lsb +: 2] == mode_key_blow)
                        next_trial = '0; // single field in blow mode
                    unique case (cmd[cmd_key_lsb +: 3])
                        param_key_gain: cur = effective.gain;
                        param_key_idle: cur = effective.idle;
                        param_key_carrier: cur = effective.carrier;
                        default: cur = effective.lock;
                    endcase
                    if (cmd[cmd_pulse_mid_bit] && cur != field_max(cmd[cmd_key_lsb +: 3]))
                        cur = clamp(cmd[cmd_key_lsb +: 3], cur + 10'h001);
                    unique case (cmd[cmd_key_lsb +: 3])
                        param_key_gain: next_trial.gain = cur;
                        param_key_idle: next_trial.idle = cur;
                        param_key_carrier: next_trial.carrier = cur;
                        param_key_lock:
                        begin
                            // address count runs freely; only calibration and lock bits
                            // have fuses, so the mask is applied at the blow, not here
                            next_trial.lock = cur;
                        end
                        default: next_trial = next_trial;
                    endcase
                    if (cmd[cmd_pulse_blow_bit] && cmd[cmd_mode_lsb +: 2] == mode_key_blow)
                    begin
                        // blow one highest addressed bit, as fuses need separate pulses
                        for (int i = 0; i < 10; i++)
                            if (cur[i])
                                bit_sel = 10'h001 << i;
                        unique case (cmd[cmd_key_lsb +: 3])
                            param_key_gain: next_blown.gain = blown.gain | bit_sel;
                            param_key_idle: next_blown.idle = blown.idle | bit_sel;
                            param_key_carrier: next_blown.carrier = blown.carrier | bit_sel;
                            param_key_lock: next_blown.lock = blown.lock | (bit_sel & (lock_code_cal | lock_code_fuse));
                            default: next_blown = next_blown;
                        endcase
                    end
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // calibration window
    // -----------------------------------------------------------------
    always_comb
    begin
        logic restart;
        restart = do_write && aw_addr == addr_command && w_strb[1:0] == 2'h3 && w_data[cmd_power_cycle_bit];
        next_period_count = period_count + 32'h00000001;
        next_periods_done = periods_done;
        next_cal_active = cal_active;
        if (period_count + 32'h00000001 >= carrier_cycles)
        begin
            next_period_count = 32'h00000000;
            if (cal_active)
                next_periods_done = periods_done + 16'h0001;
            if (cal_active && periods_done + 16'h0001 >= 16'(cal_periods))
                next_cal_active = 1'b0;
        end
        if (restart)
        begin
            next_period_count = 32'h00000000;
            next_periods_done = 16'h0000;
            next_cal_active = |(blown.lock & lock_code_cal);
        end
        next_duty = cal_active ? effective.idle : field_duty;
    end

    // -----------------------------------------------------------------
    // register readback
    // -----------------------------------------------------------------
    always_comb
    begin
        next_rvalid = rvalid && !s_axi_rready;
        next_rdata = rdata;
        next_rresp = rresp;
        if (do_read)
        begin
            next_rvalid = 1'b1;
            next_rresp = resp_okay;
            unique case (s_axi_araddr)
                addr_command: next_rdata = {27'h0, key, mode};
                addr_status: next_rdata = {30'h0, cal_active, locked};
                addr_gain: next_rdata = {22'h0, effective.gain};
                addr_idle: next_rdata = {22'h0, effective.idle};
                addr_carrier: next_rdata = {22'h0, effective.carrier};
                addr_lock: next_rdata = {22'h0, effective.lock};
                default:
                begin
                    next_rdata = 32'h00000000;
                    next_rresp = resp_slverr;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // reset acts as first power-on: blown fuse codes clear along with the trial codes
            trial <= '0;
            blown <= '0;
            mode <= 2'h0;
            key <= 3'h0;
            cal_active <= 1'b0;
            period_count <= 32'h00000000;
            periods_done <= 16'h0000;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= resp_okay;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= resp_okay;
            duty <= 10'h000;
        end
        else
        begin
            trial <= next_trial;
            blown <= next_blown;
            mode <= next_mode;
            key <= next_key;
            cal_active <= next_cal_active;
            period_count <= next_period_count;
            periods_done <= next_periods_done;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            duty <= next_duty;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign duty_select = duty;
    assign calibrating = cal_active;
    assign carrier_tick = (period_count == 32'h00000000);
    assign device_locked = locked;

endmodule

// File: design/fuse_map_pkg.sv
package fuse_map_pkg;

    // -----------------------------------------------------------------
    // mode keys
    // -----------------------------------------------------------------
    localparam logic [1:0] mode_key_blow = 2'h1;
    localparam logic [1:0] mode_key_try = 2'h2;

    // -----------------------------------------------------------------
    // parameter keys and field limits
    // -----------------------------------------------------------------
    localparam logic [2:0] param_key_gain = 3'h1;
    localparam logic [2:0] param_key_idle = 3'h2;
    localparam logic [2:0] param_key_carrier = 3'h3;
    localparam logic [2:0] param_key_lock = 3'h5;

    localparam logic [9:0] code_initial = 10'h000;
    localparam logic [9:0] gain_code_max = 10'h0ff;
    localparam logic [9:0] idle_code_max = 10'h1ff;
    localparam logic [9:0] idle_code_decrease = 10'h100;
    localparam logic [9:0] carrier_code_max = 10'h00f;
    localparam logic [9:0] lock_code_cal = 10'h010;
    localparam logic [9:0] lock_code_fuse = 10'h200;
    localparam logic [9:0] lock_code_max = 10'h3ff;

    // -----------------------------------------------------------------
    // register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] addr_command = 8'h00;
    localparam logic [7:0] addr_status = 8'h04;
    localparam logic [7:0] addr_gain = 8'h08;
    localparam logic [7:0] addr_idle = 8'h0c;
    localparam logic [7:0] addr_carrier = 8'h10;
    localparam logic [7:0] addr_lock = 8'h14;

    // command register fields
    localparam int cmd_mode_lsb = 0;
    localparam int cmd_key_lsb = 4;
    localparam int cmd_pulse_mid_bit = 8;
    localparam int cmd_pulse_blow_bit = 9;
    localparam int cmd_power_cycle_bit = 10;

    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // -----------------------------------------------------------------
    // calibration timing
    // -----------------------------------------------------------------
    localparam int clk_mhz = 200;
    localparam int cal_time_ms = 50;
    localparam int cal_target_hz = 2000;
    // fixed count of carrier periods: 50 ms at 2 kHz
    localparam int cal_periods = cal_time_ms * cal_target_hz / 1000;
    localparam int carrier_base_cycles = clk_mhz * 1000000 / cal_target_hz;
    localparam int carrier_step_cycles = carrier_base_cycles / 16;

    typedef struct packed {
        logic [9:0] gain;
        logic [9:0] idle;
        logic [9:0] carrier;
        logic [9:0] lock;
    } field_set_type;

endpackage

// File: tb/fuse_code_map_asserts.sv
`timescale 1ns/1ps
module fuse_code_map_asserts
    import fuse_map_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] field_duty,
    input wire logic [9:0] duty_select,
    input wire logic calibrating,
    input wire logic carrier_tick,
    input wire logic device_locked
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_lock_sticky: assert property (device_locked |=> device_locked)
        else $error("lock fuse lost");
    a_field_follow: assert property ($past(aresetn) && !calibrating && !$past(calibrating)
        |-> duty_select == $past(field_duty)) else $error("duty not following field");
    a_cal_hold: assert property (calibrating && $past(calibrating) && $past(calibrating, 2)
        && $past(calibrating, 3) && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
        && !$past(s_axi_wvalid, 3)
        |-> $stable(duty_select)) else $error("duty moved in calibration");
    a_tick_single: assert property (carrier_tick |=> !carrier_tick [*8])
        else $error("carrier tick too long");
endmodule

bind fuse_code_map fuse_code_map_asserts chk_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .field_duty(field_duty),
    .duty_select(duty_select),
    .calibrating(calibrating),
    .carrier_tick(carrier_tick),
    .device_locked(device_locked)
);

// File: tb/duty_meter_model.sv
`timescale 1ns/1ps
module duty_meter_model
(
    input wire logic aclk,
    input wire logic calibrating,
    input wire logic [9:0] duty_select,
    output logic [9:0] field_duty,
    output logic [9:0] cal_code
);
    int seed = 82428;

    initial
    begin
        field_duty = 10'h155;
        cal_code = 10'h3ff;
    end

    // never zero, so a held idle code is told apart from the field
    always @(posedge aclk)
    begin
        field_duty <= 10'($random(seed)) | 10'h001;
        if (calibrating)
            cal_code <= duty_select;
    end
endmodule

// File: tb/tb_fuse_code_map.sv
`timescale 1ns/1ps
module tb_fuse_code_map import fuse_map_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [9:0] field_duty, duty_select, cal_code;
    logic calibrating, carrier_tick, device_locked;
    int fail_count = 0, n_compared = 0, seed = 82428, n;

    always #2.5 aclk = ~aclk;

    fuse_code_map dut_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .field_duty(field_duty),
        .duty_select(duty_select),
        .calibrating(calibrating),
        .carrier_tick(carrier_tick),
        .device_locked(device_locked)
    );
    duty_meter_model model_u (.aclk(aclk), .calibrating(calibrating),
        .duty_select(duty_select), .field_duty(field_duty), .cal_code(cal_code));

    function automatic logic [31:0] sat(input int c, input int mx);
        return (c > mx) ? 32'(mx) : 32'(c);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, got;
        pa = 1'b1;
        pw = 1'b1;
        got = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (pa || pw)
        begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        while (!got)
        begin
            @(negedge aclk);
            got = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end
    endtask

    task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic pa, got;
        logic [31:0] d;
        logic [1:0] r;
        pa = 1'b1;
        got = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (pa)
        begin
            @(negedge aclk);
            pa = !s_axi_arready;
            @(posedge aclk);
            s_axi_arvalid <= pa;
        end
        while (!got)
        begin
            @(negedge aclk);
            got = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end
        check($sformatf("data at %h", a), exp, d);
        check($sformatf("resp at %h", a), {30'h0, er}, {30'h0, r});
    endtask

    // act bit 0 mid pulse, bit 1 blow pulse, bit 2 power cycle
    task automatic cmd(input logic [1:0] m, input logic [2:0] k, input logic [2:0] act, input int t);
        repeat (t) axi_write(addr_command, {21'h0, act, 1'b0, k, 2'h0, m}, rs);
    endtask

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 2; i < 6; i++)
            read_check(8'(4 * i), 32'h0, resp_okay);
        read_check(addr_status, 32'h0, resp_okay);
        read_check(8'h18, 32'h0, resp_slverr);
        axi_write(addr_gain, 32'h1, rs);
        check("write resp", {30'h0, resp_slverr}, {30'h0, rs});
        n = ($random(seed) & 31) + 1;
        cmd(mode_key_try, param_key_carrier, 3'h1, n);
        read_check(addr_carrier, sat(n, 15), resp_okay);
        n = ($random(seed) & 255) + 40;
        cmd(mode_key_try, param_key_gain, 3'h1, n);
        read_check(addr_gain, sat(n, 255), resp_okay);
        cmd(mode_key_try, param_key_idle, 3'h1, 258);
        read_check(addr_idle, 32'd258, resp_okay);
        cmd(2'h0, 3'h0, 3'h4, 1);
        read_check(addr_idle, 32'h0, resp_okay);
        read_check(addr_status, 32'h0, resp_okay);
        cmd(mode_key_blow, param_key_lock, 3'h1, 16);
        cmd(mode_key_blow, param_key_lock, 3'h2, 1);
        cmd(2'h0, 3'h0, 3'h4, 1);
        read_check(addr_lock, {22'h0, lock_code_cal}, resp_okay);
        read_check(addr_status, 32'h2, resp_okay);
        @(negedge aclk);
        check("calibrating", 32'h1, {31'h0, calibrating});
        check("calibration duty", 32'h0, {22'h0, cal_code});
        check("duty select", 32'h0, {22'h0, duty_select});
        cmd(mode_key_blow, param_key_lock, 3'h1, 512);
        cmd(mode_key_blow, param_key_lock, 3'h2, 1);
        read_check(addr_status, 32'h3, resp_okay);
        @(negedge aclk);
        check("device locked", 32'h1, {31'h0, device_locked});
        cmd(mode_key_try, param_key_gain, 3'h1, 3);
        read_check(addr_gain, 32'h0, resp_okay);
        final_report();
    end

    initial
    begin
        #(5 * 20000);
        fail_count++;
        final_report();
    end
endmodule
